/* File: design/twesc_cfg.svh */
`ifndef TWESC_CFG_SVH
`define TWESC_CFG_SVH

// Device type codes in the upper nibble of the address byte.
`define TWESC_TYPE_MAIN 4'ha
`define TWESC_TYPE_ID 4'hb

// Bit positions inside received bytes.
`define TWESC_RW_BIT 0
`define TWESC_LOCK_SEL_BIT 2
`define TWESC_LOCK_DATA_BIT 1

// Array and page geometry.
`define TWESC_ARRAY_AW 14
`define TWESC_ARRAY_BYTES 16384
`define TWESC_PAGE_AW 6
`define TWESC_PAGE_BYTES 64

// Bit counter positions within one byte frame.
`define TWESC_LAST_BIT 4'h7
`define TWESC_ACK_SLOT 4'h8

// Synchroniser reset levels: clock and data idle high, all else low.
`define TWESC_SYNC_RST 7'h03

// Internal write cycle: longest time in ms, clock rate in kHz.
`define TWESC_TWR_MS 5
`define TWESC_CLK_KHZ 125000
`define TWESC_TWR_CYCLES (`TWESC_TWR_MS * `TWESC_CLK_KHZ)
`define TWESC_TIMER_W 20

`endif

/* File: design/twesc_pkg.sv */
package twesc_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEVADDR = 6'h02,
    ST_ADDRH = 6'h04,
    ST_ADDRL = 6'h08,
    ST_WDATA = 6'h10,
    ST_RDATA = 6'h20
  } twesc_bus_state_t;

  typedef enum logic [2:0] {
    PG_IDLE = 3'h1,
    PG_COPY = 3'h2,
    PG_WAIT = 3'h4
  } twesc_prog_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic bit_val;
  } twesc_bus_ev_t;

  typedef struct packed {
    logic wp;
    logic [2:0] strap;
    logic tog;
    logic sda;
    logic scl;
  } twesc_pins_t;

endpackage

/* File: design/twesc_link.sv */
// Runs on the bus clock itself: each rising edge captures the data line,
// which the protocol holds steady while the clock is high.
module twesc_link
(
  // Bus clock domain
  input wire logic scl_clk_in,
  input wire logic rst_n_in,
  // Sampled line
  input wire logic sda_in,
  // Captured bit and its event toggle
  output logic bit_out,
  output logic toggle_out
);

  always_ff @(posedge scl_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bit_out <= 1'b0;
      toggle_out <= 1'b0;
    end
    else
    begin
      bit_out <= sda_in;
      toggle_out <= ~toggle_out;
    end
  end

endmodule

/* File: design/twesc_mem.sv */
// Byte-wide storage with one write port and a registered read port.
module twesc_mem
#(
  parameter int AW = 6,
  parameter int DEPTH = 64
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Write port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [7:0] wdata_in,
  // Read port
  input wire logic [AW-1:0] raddr_in,
  output logic [7:0] rdata_out
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_in)
  begin
    if (we_in)
      mem[waddr_in] <= wdata_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= 8'h00;
    else
      rdata_out <= mem[raddr_in];
  end

endmodule

/* File: design/twesc_top.sv */
`include "twesc_cfg.svh"

module twesc_top
  import twesc_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `TWESC_TWR_CYCLES
)
(
  // System clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // Two-wire bus
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  // Straps and protection
  input wire logic STRAP_SELECT_BIT0_IN,
  input wire logic STRAP_SELECT_BIT1_IN,
  input wire logic STRAP_SELECT_BIT2_IN,
  input wire logic WRITE_PROTECT_IN,
  // Status
  output logic BUSY_OUT,
  output logic STANDBY_OUT,
  output logic EXTRA_PAGE_LOCKED_OUT
);

  localparam logic [6:0] SYNC_RST = `TWESC_SYNC_RST;
  localparam logic [`TWESC_TIMER_W-1:0] TWR_LAST = `TWESC_TIMER_W'(WRITE_CYCLES - 1);

  logic [6:0] pins_raw;
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [2:0] prev_reg;
  twesc_pins_t pins_s;
  twesc_bus_ev_t ev;
  logic link_bit;
  logic link_tog;

  twesc_bus_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [6:0] shift_reg;
  logic ack_reg;
  logic id_space_reg;
  logic [7:0] addr_hi_reg;
  logic [`TWESC_ARRAY_AW-1:0] addr_reg;
  logic drive_reg;

  logic [`TWESC_PAGE_BYTES-1:0] valid_reg;
  logic lock_req_reg;
  logic locked_reg;

  twesc_prog_state_t pg_reg;
  logic [6:0] idx_reg;
  logic [`TWESC_TIMER_W-1:0] timer_reg;
  logic prog_id_reg;
  logic [`TWESC_ARRAY_AW-`TWESC_PAGE_AW-1:0] prog_page_reg;

  logic [7:0] rx_byte;
  logic rx_ok;
  logic byte_done;
  logic ninth;
  logic busy;
  logic main_match;
  logic id_match;
  logic dev_ack;
  logic lock_sel;
  logic page_ok;
  logic buf_we;
  logic launch;
  logic [`TWESC_PAGE_AW-1:0] copy_slot;
  logic copy_we;
  logic [7:0] buf_rdata;
  logic [7:0] main_rdata;
  logic [7:0] id_rdata;
  logic [7:0] tx_byte;

  function automatic logic dev_match(input logic [7:0] b, input logic [3:0] t,
                                     input logic [2:0] s);
    dev_match = (b[7:4] == t) && (b[3:1] == s);
  endfunction

  twesc_link u_link
  (
    .scl_clk_in(SCL_IN),
    .rst_n_in(RST_N_IN),
    .sda_in(SDA_IN),
    .bit_out(link_bit),
    .toggle_out(link_tog)
  );

  assign pins_raw = {WRITE_PROTECT_IN, STRAP_SELECT_BIT2_IN, STRAP_SELECT_BIT1_IN,
                     STRAP_SELECT_BIT0_IN, link_tog, SDA_IN, SCL_IN};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_sync
      always_ff @(posedge CLK_IN or negedge RST_N_IN)
      begin
        if (!RST_N_IN)
        begin
          sync1_reg[gi] <= SYNC_RST[gi];
          sync2_reg[gi] <= SYNC_RST[gi];
        end
        else
        begin
          sync1_reg[gi] <= pins_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign pins_s = sync2_reg;

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      prev_reg <= SYNC_RST[2:0];
    else
      prev_reg <= {pins_s.tog, pins_s.sda, pins_s.scl};
  end

  // The captured bit is held by the link side for a whole bus clock period,
  // so it is stable long before its toggle clears the synchroniser.
  assign ev.start = pins_s.scl & prev_reg[0] & prev_reg[1] & ~pins_s.sda;
  assign ev.stop = pins_s.scl & prev_reg[0] & ~prev_reg[1] & pins_s.sda;
  assign ev.rise = pins_s.tog ^ prev_reg[2];
  assign ev.fall = prev_reg[0] & ~pins_s.scl;
  assign ev.bit_val = link_bit;

  assign rx_byte = {shift_reg, ev.bit_val};
  assign rx_ok = ev.rise & ~ev.start & ~ev.stop & (state_reg != ST_IDLE);
  assign byte_done = rx_ok & (cnt_reg == `TWESC_LAST_BIT);
  assign ninth = rx_ok & (cnt_reg == `TWESC_ACK_SLOT);
  assign busy = (pg_reg != PG_IDLE);

  assign main_match = dev_match(rx_byte, `TWESC_TYPE_MAIN, pins_s.strap);
  assign id_match = dev_match(rx_byte, `TWESC_TYPE_ID, pins_s.strap);
  assign dev_ack = (main_match | id_match) & ~busy;

  assign lock_sel = addr_hi_reg[`TWESC_LOCK_SEL_BIT];
  assign page_ok = id_space_reg ? (~locked_reg & ~lock_sel) : ~pins_s.wp;
  assign buf_we = byte_done & (state_reg == ST_WDATA) & page_ok;

  // Bus transfer sequencer.
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 7'h00;
      ack_reg <= 1'b0;
      id_space_reg <= 1'b0;
      addr_hi_reg <= 8'h00;
      addr_reg <= '0;
    end
    else if (ev.start)
    begin
      state_reg <= ST_DEVADDR;
      cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
    end
    else if (ev.stop)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
    end
    else if (ninth)
    begin
      cnt_reg <= 4'h0;
      // The ninth pulse after a read address carries our own acknowledge,
      // so the counter moves only after a data byte that was sent out.
      if (state_reg == ST_RDATA)
      begin
        if (!ack_reg)
        begin
          if (id_space_reg)
            addr_reg[`TWESC_PAGE_AW-1:0] <= addr_reg[`TWESC_PAGE_AW-1:0] + 6'h01;
          else
            addr_reg <= addr_reg + 14'h0001;
          if (ev.bit_val)
            state_reg <= ST_IDLE;
        end
      end
      else if (!ack_reg)
        state_reg <= ST_IDLE;
    end
    else if (rx_ok)
    begin
      shift_reg <= rx_byte[6:0];
      cnt_reg <= cnt_reg + 4'h1;
      if (byte_done)
      begin
        case (state_reg)
          ST_DEVADDR:
          begin
            ack_reg <= dev_ack;
            id_space_reg <= id_match;
            if (!dev_ack)
              state_reg <= ST_IDLE;
            else if (rx_byte[`TWESC_RW_BIT])
              state_reg <= ST_RDATA;
            else
              state_reg <= ST_ADDRH;
          end
          ST_ADDRH:
          begin
            ack_reg <= 1'b1;
            addr_hi_reg <= rx_byte;
            state_reg <= ST_ADDRL;
          end
          ST_ADDRL:
          begin
            ack_reg <= 1'b1;
            addr_reg <= {addr_hi_reg[`TWESC_ARRAY_AW-9:0], rx_byte};
            state_reg <= ST_WDATA;
          end
          ST_WDATA:
          begin
            ack_reg <= id_space_reg ? ~locked_reg : 1'b1;
            addr_reg[`TWESC_PAGE_AW-1:0] <= addr_reg[`TWESC_PAGE_AW-1:0] + 6'h01;
          end
          default:
            ack_reg <= 1'b0;
        endcase
      end
    end
  end

  assign tx_byte = id_space_reg ? id_rdata : main_rdata;

  // The line is only ever released or pulled low, changing while SCL is low.
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      drive_reg <= 1'b0;
    else if (ev.start || ev.stop)
      drive_reg <= 1'b0;
    else if (ev.fall)
    begin
      if (cnt_reg == `TWESC_ACK_SLOT)
        drive_reg <= ack_reg;
      else if (state_reg == ST_RDATA)
        drive_reg <= ~tx_byte[~cnt_reg[2:0]];
      else
        drive_reg <= 1'b0;
    end
  end

  // Page buffer bookkeeping; a fresh write address clears what a prior
  // aborted session left behind.
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      valid_reg <= '0;
      lock_req_reg <= 1'b0;
    end
    else if (byte_done && state_reg == ST_DEVADDR && dev_ack && !rx_byte[`TWESC_RW_BIT])
    begin
      valid_reg <= '0;
      lock_req_reg <= 1'b0;
    end
    else if (byte_done && state_reg == ST_WDATA)
    begin
      if (buf_we)
        valid_reg[addr_reg[`TWESC_PAGE_AW-1:0]] <= 1'b1;
      if (id_space_reg && lock_sel && !locked_reg && rx_byte[`TWESC_LOCK_DATA_BIT])
        lock_req_reg <= 1'b1;
    end
  end

  assign launch = ev.stop & (state_reg == ST_WDATA) & ((|valid_reg) | lock_req_reg)
                  & ~busy;

  // Self-timed write: copy the buffered bytes, then hold busy to the end.
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      pg_reg <= PG_IDLE;
      idx_reg <= 7'h00;
      timer_reg <= '0;
      prog_id_reg <= 1'b0;
      prog_page_reg <= '0;
    end
    else
    begin
      case (pg_reg)
        PG_IDLE:
        begin
          if (launch)
          begin
            pg_reg <= PG_COPY;
            idx_reg <= 7'h00;
            timer_reg <= '0;
            prog_id_reg <= id_space_reg;
            prog_page_reg <= addr_reg[`TWESC_ARRAY_AW-1:`TWESC_PAGE_AW];
          end
        end
        PG_COPY:
        begin
          idx_reg <= idx_reg + 7'h01;
          timer_reg <= timer_reg + `TWESC_TIMER_W'(1);
          if (idx_reg == 7'(`TWESC_PAGE_BYTES))
            pg_reg <= PG_WAIT;
        end
        PG_WAIT:
        begin
          timer_reg <= timer_reg + `TWESC_TIMER_W'(1);
          if (timer_reg >= TWR_LAST)
            pg_reg <= PG_IDLE;
        end
        default:
          pg_reg <= PG_IDLE;
      endcase
    end
  end

  // Once set the lock survives everything except power-on reset.
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      locked_reg <= 1'b0;
    else if (launch && lock_req_reg)
      locked_reg <= 1'b1;
  end

  // The buffer read lags by one cycle, so slot idx-1 is written at idx.
  assign copy_slot = idx_reg[`TWESC_PAGE_AW-1:0] - 6'h01;
  assign copy_we = (pg_reg == PG_COPY) & (idx_reg != 7'h00) & valid_reg[copy_slot];

  twesc_mem #(.AW(`TWESC_PAGE_AW), .DEPTH(`TWESC_PAGE_BYTES)) u_buf
  (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .we_in(buf_we),
    .waddr_in(addr_reg[`TWESC_PAGE_AW-1:0]),
    .wdata_in(rx_byte),
    .raddr_in(idx_reg[`TWESC_PAGE_AW-1:0]),
    .rdata_out(buf_rdata)
  );

  twesc_mem #(.AW(`TWESC_ARRAY_AW), .DEPTH(`TWESC_ARRAY_BYTES)) u_array
  (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .we_in(copy_we & ~prog_id_reg),
    .waddr_in({prog_page_reg, copy_slot}),
    .wdata_in(buf_rdata),
    .raddr_in(addr_reg),
    .rdata_out(main_rdata)
  );

  twesc_mem #(.AW(`TWESC_PAGE_AW), .DEPTH(`TWESC_PAGE_BYTES)) u_idpage
  (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .we_in(copy_we & prog_id_reg),
    .waddr_in(copy_slot),
    .wdata_in(buf_rdata),
    .raddr_in(addr_reg[`TWESC_PAGE_AW-1:0]),
    .rdata_out(id_rdata)
  );

  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = drive_reg;
  assign BUSY_OUT = busy;
  assign STANDBY_OUT = (state_reg == ST_IDLE) & ~busy;
  assign EXTRA_PAGE_LOCKED_OUT = locked_reg;

endmodule

/* File: tb/twesc_master_model.sv */
// Bus master on the far side of the two-wire bus. The clock idles high
// between frames and the data line is only ever pulled low or released.
module twesc_master_model
(
  // Bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic pull_low_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    scl_out = 1'b1;
    pull_low_out = 1'b0;
  end

  // Data moves mid-way through the low phase, well away from both clock edges.
  task automatic clk_bit(input logic v, output logic s);
    #31 pull_low_out = !v;
    #31.5 scl_out = 1'b1;
    #31 s = sda_in;
    #31.5 scl_out = 1'b0;
  endtask

  task automatic start_c();
    if (!scl_out)
    begin
      #31 pull_low_out = 1'b0;
      #31.5 scl_out = 1'b1;
    end
    #62.5 pull_low_out = 1'b1;
    #62.5 scl_out = 1'b0;
  endtask

  task automatic stop_c();
    #31 pull_low_out = 1'b1;
    #31.5 scl_out = 1'b1;
    #62.5 pull_low_out = 1'b0;
    #62.5;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b1, s);
      b[i] = s;
    end
    clk_bit(!ack, s);
  endtask
endmodule

/* File: tb/twesc_top_sva.sv */
module twesc_chk
#(
  parameter int unsigned WRITE_CYCLES = 200
)
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // Two-wire bus
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_OUT,
  // Straps and protection
  input wire logic STRAP_SELECT_BIT0_IN,
  input wire logic STRAP_SELECT_BIT1_IN,
  input wire logic STRAP_SELECT_BIT2_IN,
  input wire logic WRITE_PROTECT_IN,
  // Status
  input wire logic BUSY_OUT,
  input wire logic STANDBY_OUT,
  input wire logic EXTRA_PAGE_LOCKED_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  int unsigned busy_cnt_reg;

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      busy_cnt_reg <= 0;
    else if (BUSY_OUT)
      busy_cnt_reg <= busy_cnt_reg + 1;
    else
      busy_cnt_reg <= 0;
  end

  property p_sda_low;
    SDA_OUT == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data output value not low");

  property p_oe_clock_low;
    $changed(SDA_OE_OUT) |-> !SCL_IN;
  endproperty
  a_oe_clock_low: assert property (p_oe_clock_low)
    else $error("data drive changed while clock high");

  property p_busy_quiet;
    BUSY_OUT |-> !SDA_OE_OUT && !STANDBY_OUT;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("drive or standby during write cycle");

  // A small tolerance allows for the sync stages around the cycle.
  property p_busy_len;
    $fell(BUSY_OUT) |-> busy_cnt_reg <= WRITE_CYCLES && busy_cnt_reg + 4 >= WRITE_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle length wrong");

  property p_busy_end;
    $fell(BUSY_OUT) |-> ##[0:2] STANDBY_OUT;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("no standby after write cycle");

  property p_lock_sticky;
    EXTRA_PAGE_LOCKED_OUT |=> EXTRA_PAGE_LOCKED_OUT;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock flag cleared");

  property p_busy_after_stop;
    $rose(BUSY_OUT) |-> SCL_IN && SDA_IN && $past(SCL_IN, 4);
  endproperty
  a_busy_after_stop: assert property (p_busy_after_stop)
    else $error("write cycle began without stop");

  property p_idle_released;
    STANDBY_OUT |-> !SDA_OE_OUT;
  endproperty
  a_idle_released: assert property (p_idle_released)
    else $error("data driven in standby");
endmodule

bind twesc_top twesc_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .STRAP_SELECT_BIT0_IN(STRAP_SELECT_BIT0_IN),
  .STRAP_SELECT_BIT1_IN(STRAP_SELECT_BIT1_IN), .STRAP_SELECT_BIT2_IN(STRAP_SELECT_BIT2_IN),
  .WRITE_PROTECT_IN(WRITE_PROTECT_IN), .BUSY_OUT(BUSY_OUT), .STANDBY_OUT(STANDBY_OUT),
  .EXTRA_PAGE_LOCKED_OUT(EXTRA_PAGE_LOCKED_OUT));

/* File: tb/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  // Reset starts released so that asserting it is a real falling edge for
  // every flop, the link sampler included, whose own clock is idle.
  logic rst_n = 1'b1;
  logic wp = 1'b0;
  logic [2:0] strap = 3'h5;
  logic sda_oe, sda_o, busy, stby, locked, scl, m_low;
  wire logic sda = !(sda_oe | m_low);
  int fails = 0;
  int n_checks = 0;
  logic [7:0] q [4];

  always #4 clk = ~clk;

  twesc_master_model m (.sda_in(sda), .scl_out(scl), .pull_low_out(m_low));

  twesc_top #(.WRITE_CYCLES(200)) uut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o),
    .SDA_OE_OUT(sda_oe), .STRAP_SELECT_BIT0_IN(strap[0]), .STRAP_SELECT_BIT1_IN(strap[1]),
    .STRAP_SELECT_BIT2_IN(strap[2]), .WRITE_PROTECT_IN(wp), .BUSY_OUT(busy),
    .STANDBY_OUT(stby), .EXTRA_PAGE_LOCKED_OUT(locked));

  task automatic tally_and_finish();
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic adr(input logic [3:0] typ, input logic rw, input logic [2:0] s, input logic e);
    logic a;
    m.start_c();
    m.send_byte({typ, s, rw}, a);
    chk(a, e);
  endtask

  // Sends the location high byte first; fin low leaves the frame open.
  task automatic wr(input logic [3:0] typ, input logic [15:0] loc, input int n,
                    input logic e, input logic fin);
    logic a;
    adr(typ, 1'b0, strap, 1'b1);
    m.send_byte(loc[15:8], a);
    chk(a, 1'b1);
    m.send_byte(loc[7:0], a);
    chk(a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      m.send_byte(q[i], a);
      chk(a, e);
    end
    if (fin)
      m.stop_c();
  endtask

  task automatic rd(input logic [3:0] typ, input logic [15:0] loc, input logic set, input int n);
    logic [7:0] b;
    if (set)
      wr(typ, loc, 0, 1'b1, 1'b0);
    adr(typ, 1'b1, strap, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      m.recv_byte(i < n - 1, b);
      chk(b, q[i]);
    end
    m.stop_c();
  endtask

  task automatic wait_cycle(input logic e, input logic poll);
    int k;
    @(posedge clk);
    #1;
    for (k = 0; k < 20 && busy !== 1'b1; k++)
      #8;
    chk(busy, e);
    if (poll)
    begin
      adr(4'ha, 1'b0, strap, 1'b0);
      m.stop_c();
    end
    for (k = 0; k < 400 && busy !== 1'b0; k++)
      #8;
    if (k == 400)
    begin
      fails++;
      tally_and_finish();
    end
    #16 chk(stby, 1'b1);
  endtask

  initial
  begin
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({sda_o, sda_oe, busy, stby, locked}, 5'h02);
    rst_n = 1'b1;
    #43.3;
    adr(4'ha, 1'b0, ~strap, 1'b0);
    m.stop_c();
    adr(4'h9, 1'b1, strap, 1'b0);
    m.stop_c();
    q = '{8'h11, 8'h22, 8'h33, 8'h44};
    wr(4'ha, 16'hc000, 2, 1'b1, 1'b1);
    wait_cycle(1'b1, 1'b0);
    q = '{8'ha1, 8'ha2, 8'ha3, 8'h00};
    wr(4'ha, 16'h3ffe, 3, 1'b1, 1'b1);
    wait_cycle(1'b1, 1'b1);
    adr(4'ha, 1'b0, strap, 1'b1);
    m.stop_c();
    q[0] = 8'h5a;
    wr(4'ha, 16'h0001, 1, 1'b1, 1'b0);
    q[0] = 8'h22;
    rd(4'ha, 16'h0001, 1'b1, 1);
    q[0] = 8'ha3;
    rd(4'ha, 16'h3fc0, 1'b1, 1);
    q = '{8'ha1, 8'ha2, 8'h11, 8'h00};
    rd(4'ha, 16'h3ffe, 1'b1, 3);
    q[0] = 8'h22;
    rd(4'ha, 16'h0000, 1'b0, 1);
    @(posedge clk);
    #1 wp = 1'b1;
    q[0] = 8'h99;
    wr(4'ha, 16'h0000, 1, 1'b1, 1'b1);
    wait_cycle(1'b0, 1'b0);
    wp = 1'b0;
    q[0] = 8'h11;
    rd(4'ha, 16'h0000, 1'b1, 1);
    q[0] = 8'hc3;
    wr(4'hb, 16'hf8c5, 1, 1'b1, 1'b1);
    wait_cycle(1'b1, 1'b0);
    rd(4'hb, 16'h0005, 1'b1, 1);
    q[0] = 8'h02;
    wr(4'hb, 16'h0400, 1, 1'b1, 1'b1);
    wait_cycle(1'b1, 1'b0);
    chk(locked, 1'b1);
    q[0] = 8'h00;
    wr(4'hb, 16'h0005, 1, 1'b0, 1'b1);
    q[0] = 8'hc3;
    rd(4'hb, 16'h0005, 1'b1, 1);
    tally_and_finish();
  end
endmodule
